// ---- src/fclp_pkg.sv ----
// fclp_pkg: constants and types of the login payload engine
// assumes: byte-wide payload streams, 32-bit APB register window
package fclp_pkg;

	// ----------------
	// register map (byte addresses)
	// ----------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_UID = 8'h04;
	localparam logic [7:0] REG_MAKER = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_NAME_A_HI = 8'h10;
	localparam logic [7:0] REG_NAME_A_LO = 8'h14;
	localparam logic [7:0] REG_NAME_B_HI = 8'h18;
	localparam logic [7:0] REG_NAME_B_LO = 8'h1c;
	localparam logic [7:0] REG_RXSIZE = 8'h20;
	localparam logic [7:0] REG_ALPA = 8'h24;
	localparam int CTRL_GO = 0;
	localparam int CTRL_PORT = 1;
	localparam int STAT_SIZE_ERR = 4;
	localparam int STAT_LOGOUT = 5;
	// arbitrary neutral reset values
	localparam logic [23:0] UID_RST = 24'h000001;
	localparam logic [23:0] MAKER_RST = 24'h5a3c96;

	// ----------------
	// payload codes and layout
	// ----------------
	localparam logic [7:0] CMD_PLOGI = 8'h03;
	localparam logic [7:0] CMD_PRLI = 8'h20;
	localparam logic [7:0] CMD_PDISC = 8'h50;
	localparam logic [7:0] CMD_FLOGI = 8'h04;
	localparam logic [7:0] ELS_ACC = 8'h02;
	localparam logic [7:0] ELS_RJT = 8'h01;
	localparam logic [7:0] LSRJT_REASON = 8'h03;
	localparam logic [7:0] VER_BYTE = 8'h09;
	localparam logic [63:0] PRLI_HDR = 64'h2010001408002000;
	localparam logic [31:0] PRLI_TAIL = 32'h00000022;
	localparam logic [11:0] LEN_PLOGI = 12'd116;
	localparam logic [11:0] LEN_PRLI = 12'd20;
	localparam logic [11:0] LEN_PDISC = 12'd28;
	localparam logic [11:0] LEN_RJT = 12'd8;
	localparam logic [11:0] IDX_VER = 12'd4;
	localparam logic [11:0] IDX_CF = 12'd8;
	localparam logic [11:0] IDX_FSC = 12'd10;
	localparam logic [11:0] IDX_PN = 12'd20;
	localparam logic [11:0] IDX_SO = 12'd68;
	localparam logic [11:0] IDX_IC = 12'd70;
	localparam logic [11:0] IDX_FS3 = 12'd74;
	localparam logic [11:0] IDX_CS = 12'd77;
	localparam logic [11:0] IDX_OS = 12'd80;
	localparam logic [11:0] IDX_PTAIL = 12'd16;
	localparam int CF_CIO = 7;
	localparam int CF_NF = 4;
	localparam int CF_ACM = 3;
	localparam int SO_VALID = 7;
	localparam int IC_ASSOC_HI = 5;
	localparam logic [15:0] FS_MIN = 16'd128;
	localparam logic [15:0] FS_MAX = 16'd2112;
	localparam logic [15:0] FS_FLOGI = 16'h0840;
	localparam logic [1:0] PORT_NODE = 2'd0;
	localparam logic [1:0] PORT_A = 2'd1;
	localparam logic [1:0] PORT_B = 2'd2;

	// ----------------
	// task management
	// ----------------
	localparam logic [7:0] TMF_ABORT_SET = 8'h02;
	localparam logic [7:0] TMF_CLEAR_SET = 8'h04;
	localparam logic [7:0] TMF_TARGET_RESET = 8'h20;
	localparam logic [7:0] TMF_CLEAR_ACA = 8'h40;
	localparam logic [7:0] TMF_TERMINATE = 8'h80;
	localparam logic [7:0] TMF_COMPLETE = 8'h00;
	localparam logic [7:0] TMF_UNSUPPORTED = 8'h04;
	localparam logic [7:0] TMF_REJECT = 8'h05;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RX = 2'b01,
		ST_TX = 2'b10
	} fclp_state_e;

	typedef enum logic [1:0] {
		TK_PACC = 2'b00,
		TK_RACC = 2'b01,
		TK_RJT = 2'b10,
		TK_FLOGI = 2'b11
	} fclp_kind_e;

endpackage

// ---- src/fclp_payload_rom.sv ----
// fclp_payload_rom: byte image of every payload the engine sends
// assumes: caller registers the byte; lookup is purely combinational
`timescale 1ns/1ps
module fclp_payload_rom (
	input wire fclp_pkg::fclp_kind_e kind, // payload being built
	input wire logic [11:0] idx, // byte position
	input wire logic [3:0] nib, // link side nibble
	input wire logic [15:0] fs, // receive size to advertise
	input wire logic [23:0] uid, // unique identifier
	input wire logic [23:0] maker, // maker code bytes
	output logic [7:0] byteOut // payload byte
);
	import fclp_pkg::*;

	logic isFlogi;
	assign isFlogi = (kind == TK_FLOGI);

	// ----------------
	// byte lookup
	// ----------------
	// image lookup per payload kind
	always_comb begin
		byteOut = 8'h00;
		case (kind)
			TK_RJT: begin
				if (idx == 12'd0) byteOut = ELS_RJT;
				else if (idx == 12'd5) byteOut = LSRJT_REASON;
			end
			TK_RACC: begin
				case (idx)
					12'd0: byteOut = ELS_ACC;
					12'd1: byteOut = 8'h10;
					12'd3: byteOut = 8'h14;
					12'd4: byteOut = 8'h08;
					12'd6: byteOut = 8'h21;
					12'd19: byteOut = 8'h12;
					default: byteOut = 8'h00;
				endcase
			end
			default: begin
				case (idx)
					12'd0: byteOut = isFlogi ? CMD_FLOGI : ELS_ACC;
					12'd4, 12'd5: byteOut = VER_BYTE;
					12'd8: byteOut = isFlogi ? 8'h08 : 8'h88;
					12'd10, 12'd74: byteOut = fs[15:8];
					12'd11, 12'd75: byteOut = fs[7:0];
					12'd13, 12'd77: byteOut = isFlogi ? 8'h00 : 8'hff;
					12'd15, 12'd81: byteOut = isFlogi ? 8'h00 : 8'h01;
					12'd18: byteOut = isFlogi ? 8'h02 : 8'h01;
					12'd19: byteOut = 8'hf4;
					12'd20: byteOut = {4'h2, nib};
					12'd22, 12'd30: byteOut = maker[23:16];
					12'd23, 12'd31: byteOut = maker[15:8];
					12'd24, 12'd32: byteOut = maker[7:0];
					12'd25, 12'd33: byteOut = uid[23:16];
					12'd26, 12'd34: byteOut = uid[15:8];
					12'd27, 12'd35: byteOut = uid[7:0];
					12'd28: byteOut = isFlogi ? 8'h02 : 8'h20;
					12'd68: byteOut = 8'h80;
					default: byteOut = 8'h00;
				endcase
			end
		endcase
	end

endmodule

// ---- src/fclp_login_engine.sv ----
// fclp_login_engine: login payload checks and replies
// fabric logins, task management, APB registers
// assumes: streams and APB master on mclk
//
// Notes on behaviour
// - task management codes 00 complete, 04 unsupported, 05 rejected
// - don't-care nibbles and bits never checked
// - incoming credit ignored; own credit zero
// - features need offset 1, N/F 0, alt credit 1; accept shows 88 00
// - both receive sizes above 128, below 2112, multiple of four
// - non-last frames carry exactly the class 3 size
// - port name kept; discovery mismatch logs out, rejects
// - incoming node name neither checked nor kept
// - class 3 valid bit must be 1; other bits ignored
// - process association 10 or 11 rejects
// - concurrent and open sequence counts must be nonzero
// - port login accept: fixed header, zero classes 1/2, options 80
// - accept returns the initiator's class 3 size; only ports A and B use it, node side keeps 0840
// - own unique id in port and node names
// - maker code bytes fill bytes 22-24 and 30-32
// - accept side nibble: 0 node, 1 port A, 2 port B
// - process accept 02 10 00 14 08 00 21 00, ends 12
// - fabric login: fixed header, credit 0, features 08 00, size 0840
// - fabric login side nibble 1 port A, 2 port B
// - clear ACA, target reset, clear/abort task set supported; terminate not
`timescale 1ns/1ps
module fclp_login_engine #(
	parameter int ADDR_W = 8 // APB address width
) (
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic rxValid, // incoming byte valid
	output logic rxReady, // engine takes bytes
	input wire logic [7:0] rxData, // incoming payload byte
	input wire logic rxSof, // first byte of frame
	input wire logic rxEof, // last byte of frame
	input wire logic [1:0] rxPort, // receiving side
	input wire logic [7:0] rxAlpa, // sender loop address
	input wire logic rxLs, // link service frame
	input wire logic rxLast, // frame ends its sequence
	output logic txValid, // outgoing byte valid
	input wire logic txReady, // link takes byte
	output logic [7:0] txData, // outgoing payload byte
	output logic txSof, // first byte of payload
	output logic txEof, // last byte of payload
	output logic [1:0] txPort, // side to send on
	output logic [15:0] txFrameSize, // own frame size
	input wire logic tmfValid, // tmf request
	input wire logic [7:0] tmfFlags, // tmf flags
	output logic tmfRespValid, // response pulse
	output logic [7:0] tmfResp // response code
);
	import fclp_pkg::*;

	if (ADDR_W < 6 || ADDR_W > 32) begin : gChk
		$error("ADDR_W must lie between 6 and 32");
	end

	typedef struct packed {
		fclp_state_e st;
		logic [11:0] idx;
		logic [7:0] cmd;
		logic [1:0] port;
		logic [7:0] alpa;
		logic bad;
		logic [7:0] tmp;
		logic [63:0] name;
		logic [15:0] fs3;
		logic [1:0] loggedIn;
		logic [1:0] prliOk;
		logic [1:0][63:0] pname;
		logic [1:0][15:0] pfs;
		logic [1:0][7:0] palpa;
		logic sizeErr;
		logic implLogout;
		logic [7:0] lastRej;
		logic flogiReq;
		logic [1:0] flogiPort;
		logic [23:0] uid;
		logic [23:0] maker;
		fclp_kind_e kind;
		logic [1:0] txPort;
		logic [3:0] txNib;
		logic [15:0] txFs;
		logic txValid;
		logic [7:0] txData;
		logic tmfRespValid;
		logic [7:0] tmfResp;
		logic [31:0] prdata;
	} fclp_eng_s;

	fclp_eng_s r;
	fclp_eng_s n;
	logic [1:0] rstPipe;
	logic rstn;
	logic [11:0] romIdx;
	logic [7:0] romByte;
	logic apbWr;
	logic [7:0] regAddr;

	// ----------------
	// helpers
	// ----------------
	function automatic logic fsOk(input logic [15:0] v);
		return (v > FS_MIN) && (v < FS_MAX) && (v[1:0] == 2'b00);
	endfunction

	function automatic logic [11:0] lenOf(input fclp_kind_e k);
		case (k)
			TK_RACC: return LEN_PRLI;
			TK_RJT: return LEN_RJT;
			default: return LEN_PLOGI;
		endcase
	endfunction

	function automatic logic isAB(input logic [1:0] p);
		return (p == PORT_A) || (p == PORT_B);
	endfunction

	// one supported function at a time completes
	function automatic logic [7:0] tmfCode(input logic [7:0] f);
		case (f)
			TMF_ABORT_SET, TMF_CLEAR_SET, TMF_TARGET_RESET, TMF_CLEAR_ACA: return TMF_COMPLETE;
			TMF_TERMINATE: return TMF_UNSUPPORTED;
			default: return TMF_REJECT;
		endcase
	endfunction

	// per-byte check; unlisted positions are don't-care
	function automatic logic byteBad(input logic [7:0] cmd, input logic [11:0] pos,
		input logic [7:0] d, input logic [7:0] hi);
		logic b;
		b = 1'b0;
		if (cmd == CMD_PLOGI) begin
			if (pos > 12'd0 && pos < IDX_VER) b = (d != 8'h00);
			else if (pos == IDX_VER || pos == IDX_VER + 12'd1) b = (d != VER_BYTE);
			else if (pos == IDX_CF) b = !d[CF_CIO] || d[CF_NF] || !d[CF_ACM];
			else if (pos == IDX_FSC + 12'd1) b = !fsOk({hi, d});
			else if (pos == IDX_SO) b = !d[SO_VALID];
			else if (pos == IDX_IC) b = d[IC_ASSOC_HI];
			else if (pos == IDX_FS3 + 12'd1) b = !fsOk({hi, d});
			else if (pos == IDX_CS) b = (d == 8'h00);
			else if (pos == IDX_OS + 12'd1) b = ({hi, d} == 16'h0000);
		end else if (cmd == CMD_PRLI) begin
			if (pos < IDX_VER + 12'd4) b = (d != 8'(PRLI_HDR >> {3'd7 - pos[2:0], 3'b000}));
			else if (pos >= IDX_PTAIL && pos < LEN_PRLI)
				b = (d != 8'(PRLI_TAIL >> {2'd3 - pos[1:0], 3'b000}));
		end
		return b;
	endfunction

	function automatic fclp_eng_s rstVal();
		fclp_eng_s v;
		v = '0;
		v.uid = UID_RST;
		v.maker = MAKER_RST;
		v.flogiPort = PORT_A;
		return v;
	endfunction

	// ----------------
	// reset release and state register
	// ----------------
	// two-stage reset release
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) rstPipe <= 2'b00;
		else rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstn = rstPipe[1];

	// single state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) r <= rstVal();
		else r <= n;
	end

	// ----------------
	// payload image
	// ----------------
	assign romIdx = r.txValid ? r.idx + 12'd1 : r.idx;

	fclp_payload_rom uRom (
		.kind(r.kind),
		.idx(romIdx),
		.nib(r.txNib),
		.fs(r.txFs),
		.uid(r.uid),
		.maker(r.maker),
		.byteOut(romByte)
	);

	assign apbWr = psel && penable && pwrite;
	assign regAddr = 8'(paddr);

	// ----------------
	// next-state logic
	// ----------------
	always_comb begin
		logic [11:0] pos;
		logic [7:0] cmdNow;
		logic pi;
		logic ok;
		pos = rxSof ? 12'd0 : r.idx;
		cmdNow = rxSof ? rxData : r.cmd;
		pi = (rxSof ? rxPort : r.port) == PORT_B;
		ok = 1'b0;
		n = r;
		n.tmfRespValid = 1'b0;

		// task management answer, one cycle later
		if (tmfValid) begin
			n.tmfRespValid = 1'b1;
			n.tmfResp = tmfCode(tmfFlags);
		end

		// read data captured in setup phase
		if (psel && !penable) begin
			case (regAddr)
				REG_CTRL: n.prdata = {29'h0, r.flogiPort, r.flogiReq};
				REG_UID: n.prdata = {8'h00, r.uid};
				REG_MAKER: n.prdata = {8'h00, r.maker};
				REG_STATUS: n.prdata = {16'h0000, r.lastRej, 1'b0, r.st != ST_IDLE,
					r.implLogout, r.sizeErr, r.prliOk, r.loggedIn};
				REG_NAME_A_HI: n.prdata = r.pname[0][63:32];
				REG_NAME_A_LO: n.prdata = r.pname[0][31:0];
				REG_NAME_B_HI: n.prdata = r.pname[1][63:32];
				REG_NAME_B_LO: n.prdata = r.pname[1][31:0];
				REG_RXSIZE: n.prdata = {r.pfs[1], r.pfs[0]};
				REG_ALPA: n.prdata = {16'h0000, r.palpa[1], r.palpa[0]};
				default: n.prdata = 32'h0;
			endcase
		end

		// register writes; sticky clears come before hardware sets
		if (apbWr) begin
			case (regAddr)
				REG_CTRL: n.flogiPort = pwdata[CTRL_PORT+:2];
				REG_UID: n.uid = pwdata[23:0];
				REG_MAKER: n.maker = pwdata[23:0];
				REG_STATUS: begin
					if (pwdata[STAT_SIZE_ERR]) n.sizeErr = 1'b0;
					if (pwdata[STAT_LOGOUT]) n.implLogout = 1'b0;
				end
				default: ;
			endcase
		end

		// receive, reply and fabric login sequencing
		case (r.st)
			ST_IDLE, ST_RX: begin
				if (rxValid) begin
					n.st = ST_RX;
					n.idx = pos + 12'd1;
					if (rxSof) begin
						n.cmd = rxData;
						n.port = rxPort;
						n.alpa = rxAlpa;
						n.bad = 1'b0;
					end
					if (rxLs) begin
						n.bad = n.bad | byteBad(cmdNow, pos, rxData, r.tmp);
						if (pos == IDX_FSC || pos == IDX_FS3 || pos == IDX_OS) n.tmp = rxData;
						if (pos >= IDX_PN && pos < IDX_PN + 12'd8) n.name = {r.name[55:0], rxData};
						if (pos == IDX_FS3 + 12'd1) n.fs3 = {r.tmp, rxData};
					end
					if (rxEof && !rxLs) begin
						n.st = ST_IDLE;
						if (!rxLast && isAB(n.port) && r.loggedIn[pi] && {4'h0, pos + 12'd1} != r.pfs[pi])
							n.sizeErr = 1'b1;
					end else if (rxEof) begin
						n.st = ST_TX;
						n.idx = 12'd0;
						n.txValid = 1'b0;
						n.txPort = n.port;
						n.txNib = {2'b00, n.port};
						case (cmdNow)
							CMD_PLOGI: begin
								ok = !n.bad && pos + 12'd1 >= LEN_PLOGI && n.port != 2'd3;
								n.kind = TK_PACC;
								n.txFs = n.fs3;
								if (ok && isAB(n.port)) begin
									n.loggedIn[pi] = 1'b1;
									n.prliOk[pi] = 1'b0;
									n.pname[pi] = n.name;
									n.pfs[pi] = n.fs3;
									n.palpa[pi] = n.alpa;
								end
							end
							CMD_PRLI: begin
								ok = !n.bad && pos + 12'd1 >= LEN_PRLI && isAB(n.port) && r.loggedIn[pi];
								n.kind = TK_RACC;
								if (ok) n.prliOk[pi] = 1'b1;
							end
							CMD_PDISC: begin
								ok = pos + 12'd1 >= LEN_PDISC && isAB(n.port) && r.loggedIn[pi];
								n.kind = TK_PACC;
								n.txFs = r.pfs[pi];
								if (ok && (n.name != r.pname[pi] || n.alpa != r.palpa[pi])) begin
									ok = 1'b0;
									n.loggedIn[pi] = 1'b0;
									n.prliOk[pi] = 1'b0;
									n.implLogout = 1'b1;
								end
							end
							default: ok = 1'b0;
						endcase
						if (!ok) begin
							n.kind = TK_RJT;
							n.lastRej = cmdNow;
						end
					end
				end else if (r.st == ST_IDLE && r.flogiReq) begin
					n.st = ST_TX;
					n.idx = 12'd0;
					n.txValid = 1'b0;
					n.flogiReq = 1'b0;
					n.kind = TK_FLOGI;
					n.txPort = r.flogiPort;
					n.txNib = {2'b00, r.flogiPort};
					n.txFs = FS_FLOGI;
				end
			end
			ST_TX: begin
				if (!r.txValid) begin
					n.txValid = 1'b1;
					n.txData = romByte;
				end else if (txReady) begin
					if (r.idx == lenOf(r.kind) - 12'd1) begin
						n.txValid = 1'b0;
						n.st = ST_IDLE;
					end else begin
						n.idx = r.idx + 12'd1;
						n.txData = romByte;
					end
				end
			end
			default: n.st = ST_IDLE;
		endcase

		// software request wins over the hardware consume
		if (apbWr && regAddr == REG_CTRL && pwdata[CTRL_GO]) n.flogiReq = 1'b1;
	end

	// ----------------
	// outputs
	// ----------------
	// bus answer in the access phase
	assign prdata = r.prdata;
	assign pready = psel && penable;
	assign pslverr = psel && penable && (paddr > ADDR_W'(REG_ALPA) || paddr[1:0] != 2'b00);

	// streams and status
	assign rxReady = (r.st != ST_TX);
	assign txValid = r.txValid;
	assign txData = r.txData;
	assign txSof = r.txValid && r.idx == 12'd0;
	assign txEof = r.txValid && r.idx == lenOf(r.kind) - 12'd1;
	assign txPort = r.txPort;
	assign txFrameSize = (isAB(r.txPort) && r.loggedIn[r.txPort == PORT_B]) ?
		r.pfs[r.txPort == PORT_B] : FS_FLOGI;
	assign tmfRespValid = r.tmfRespValid;
	assign tmfResp = r.tmfResp;

endmodule

// ---- verif/fclp_login_monitor.sv ----
// fclp_login_monitor: port checks of the login payload engine
// assumes: bound to fclp_login_engine, one clock domain
`timescale 1ns/1ps
module fclp_login_monitor (
	input logic mclk, // system clock
	input logic nrst, // async reset, low
	input logic rxValid, // byte valid
	input logic rxReady, // engine takes bytes
	input logic rxEof, // last rx byte
	input logic rxLs, // link service frame
	input logic txValid, // reply byte valid
	input logic txReady, // link takes byte
	input logic [7:0] txData, // reply byte
	input logic txSof, // first reply byte
	input logic [15:0] txFrameSize, // own frame size
	input logic tmfValid, // tmf request
	input logic [7:0] tmfFlags, // tmf flags
	input logic tmfRespValid, // tmf pulse
	input logic [7:0] tmfResp // tmf code
);
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	a_tmf_done: assert property (
		tmfValid && tmfFlags inside {8'h02, 8'h04, 8'h20, 8'h40}
		|=> tmfRespValid && tmfResp == 8'h00) else $error("tmf 00 wrong");
	a_tmf_unsup: assert property (
		tmfValid && tmfFlags == 8'h80 |=> tmfRespValid && tmfResp == 8'h04)
		else $error("tmf 04 wrong");
	a_tmf_reject: assert property (
		tmfValid && !(tmfFlags inside {8'h02, 8'h04, 8'h20, 8'h40, 8'h80})
		|=> tmfRespValid && tmfResp == 8'h05) else $error("tmf 05 wrong");
	a_reply_start: assert property (
		rxValid && rxReady && rxEof && rxLs |-> ##[1:3] (txValid && txSof))
		else $error("no reply");
	a_rx_blocked: assert property (
		rxValid && rxReady && rxEof && rxLs |=> !rxReady [*2]) else $error("rx not blocked");
	a_tx_hold: assert property (
		txValid && !txReady |=> txValid && $stable(txData) && $stable(txSof))
		else $error("byte not held");
	a_first_byte: assert property (
		txValid && txSof |-> txData inside {8'h01, 8'h02, 8'h04}) else $error("bad first byte");
	a_size_legal: assert property (
		txFrameSize == 16'h0840 || (txFrameSize > 16'd128 && txFrameSize < 16'd2112
		&& txFrameSize[1:0] == 2'b00)) else $error("bad frame size");
endmodule

bind fclp_login_engine fclp_login_monitor u_mon (.mclk(mclk), .nrst(nrst), .rxValid(rxValid),
	.rxReady(rxReady), .rxEof(rxEof), .rxLs(rxLs), .txValid(txValid), .txReady(txReady),
	.txData(txData), .txSof(txSof), .txFrameSize(txFrameSize), .tmfValid(tmfValid),
	.tmfFlags(tmfFlags), .tmfRespValid(tmfRespValid), .tmfResp(tmfResp));

// ---- verif/fclp_initiator_model.sv ----
// fclp_initiator_model: far-side initiator feeding frames, taking replies
// assumes: engine byte handshakes on mclk
`timescale 1ns/1ps
module fclp_initiator_model (
	input logic mclk, // system clock
	output logic rxValid, // byte valid
	input logic rxReady, // engine takes bytes
	output logic [7:0] rxData, // payload byte
	output logic rxSof, // first byte
	output logic rxEof, // last byte
	output logic [1:0] rxPort, // receiving side
	output logic [7:0] rxAlpa, // own loop address
	output logic rxLs, // link service frame
	output logic rxLast, // last of sequence
	output logic txReady // reply byte taken
);
	typedef logic [7:0] fclp_bq_t[$];
	// idle levels
	initial begin
		rxValid = 1'b0;
		rxData = 8'h00;
		rxSof = 1'b0;
		rxEof = 1'b0;
		rxPort = 2'd1;
		rxAlpa = 8'h2a;
		rxLs = 1'b1;
		rxLast = 1'b0;
		txReady = 1'b0;
	end
	// reply sink stalls now and then
	always @(posedge mclk) txReady <= ($urandom_range(3) != 0);
	// one frame, bytes held until taken
	task automatic send(input fclp_bq_t b, input logic [1:0] p, input logic ls, input logic last);
		foreach (b[i]) begin
			rxValid <= 1'b1;
			rxData <= b[i];
			rxSof <= (i == 0);
			rxEof <= (i == b.size() - 1);
			rxPort <= p;
			rxLs <= ls;
			rxLast <= last;
			do @(posedge mclk); while (rxReady !== 1'b1);
		end
		rxValid <= 1'b0;
		rxSof <= 1'b0;
		rxEof <= 1'b0;
		rxData <= ~b[b.size() - 1]; // no stale byte on idle line
	endtask
endmodule

// ---- verif/testbench.sv ----
// testbench: self-checking bench for the login payload engine
// assumes: fclp_pkg, initiator model and monitor compiled alongside
`timescale 1ns/1ps
module testbench;
	import fclp_pkg::*;
	logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic tmfValid = 1'b0;
	logic [7:0] tmfFlags = 8'h00;
	logic [31:0] prdata;
	logic pready, pslverr, rxValid, rxReady, rxSof, rxEof, rxLs, rxLast;
	logic txValid, txReady, txSof, txEof, tmfRespValid;
	logic [7:0] rxData, rxAlpa, txData, tmfResp, f;
	logic [1:0] rxPort, txPort, ep;
	logic [15:0] txFrameSize;
	logic [7:0] fr[$], txq[$], tq[$];
	logic [32:0] ae[$], am[$];
	logic [23:0] uid, mk;
	logic [63:0] pn;
	int nFail = 0, checkCount = 0, cyc = 0;
	logic [7:0] tab[9] = '{8'h02, 8'h04, 8'h20, 8'h40, 8'h80, 8'h00, 8'h10, 8'h03, 8'hff};
	logic [23:0] bad[14] = '{24'h080800, 24'h089800, 24'h088000, 24'h0a0080, 24'h0a0840,
		24'h0a0102, 24'h4a0080, 24'h4a0840, 24'h4a07fe, 24'h447f00, 24'h462000, 24'h463000,
		24'h4c0000, 24'h500000};

	fclp_login_engine dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .rxSof(rxSof),
		.rxEof(rxEof), .rxPort(rxPort), .rxAlpa(rxAlpa), .rxLs(rxLs), .rxLast(rxLast),
		.txValid(txValid), .txReady(txReady), .txData(txData), .txSof(txSof), .txEof(txEof),
		.txPort(txPort), .txFrameSize(txFrameSize), .tmfValid(tmfValid), .tmfFlags(tmfFlags),
		.tmfRespValid(tmfRespValid), .tmfResp(tmfResp));
	fclp_initiator_model ini (.mclk(mclk), .rxValid(rxValid), .rxReady(rxReady),
		.rxData(rxData), .rxSof(rxSof), .rxEof(rxEof), .rxPort(rxPort), .rxAlpa(rxAlpa),
		.rxLs(rxLs), .rxLast(rxLast), .txReady(txReady));

	// ----------------
	// helpers
	// ----------------
	always #5 mclk = ~mclk;
	task automatic chk(input string s, input logic [32:0] e, g);
		checkCount++;
		if (g !== e) begin
			nFail++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// reply byte: 0 port acc, 1 process acc, 2 reject, 3 fabric login
	function automatic logic [7:0] eb(input int k, input int i, input logic [3:0] nb,
		input logic [15:0] fs);
		logic fl;
		fl = (k == 3);
		if (k == 1)
			return i < 8 ? 8'(64'h0210001408002100 >> (56 - 8 * i)) : 8'(i == 19 ? 8'h12 : 0);
		if (k == 2)
			return i == 0 ? 8'h01 : (i == 5 ? 8'h03 : 8'h00);
		case (i)
			0: return fl ? 8'h04 : 8'h02;
			4, 5: return 8'h09;
			8: return fl ? 8'h08 : 8'h88;
			10, 74: return fs[15:8];
			11, 75: return fs[7:0];
			13, 77: return fl ? 8'h00 : 8'hff;
			15, 81: return fl ? 8'h00 : 8'h01;
			18: return fl ? 8'h02 : 8'h01;
			19: return 8'hf4;
			20: return {4'h2, nb};
			22, 30: return mk[23:16];
			23, 31: return mk[15:8];
			24, 32: return mk[7:0];
			25, 33: return uid[23:16];
			26, 34: return uid[15:8];
			27, 35: return uid[7:0];
			28: return fl ? 8'h02 : 8'h20;
			68: return 8'h80;
			default: return 8'h00;
		endcase
	endfunction
	task automatic expect_reply(input int k, input logic [3:0] nb, input logic [15:0] fs);
		for (int i = 0; i < (k == 1 ? 20 : (k == 2 ? 8 : 116)); i++) txq.push_back(eb(k, i, nb, fs));
	endtask
	task automatic wait_reply;
		for (int n = 0; n < 2000 && txq.size() != 0; n++) @(posedge mclk);
		repeat (3) @(posedge mclk);
		chk("reply drained", '0, {32'h0, txq.size() != 0});
	endtask
	task automatic xfer(input logic [1:0] p, input logic ls, input logic last);
		ep = p;
		ini.send(fr, p, ls, last);
		wait_reply();
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, m);
		if (!w) begin
			ae.push_back(e & m);
			am.push_back(m);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// port login, random where unchecked
	task automatic plogi(input logic [1:0] p, input logic [15:0] fs, input logic [23:0] ov,
		input int k);
		fr = {};
		for (int i = 0; i < 116; i++) fr.push_back(8'($urandom));
		{fr[0], fr[1], fr[2], fr[3], fr[4], fr[5]} = 48'h030000000909;
		fr[8] = 8'h88 | (fr[8] & 8'h67);
		{fr[10], fr[11]} = 16'h0100;
		fr[68] = 8'h80 | (fr[68] & 8'h7f);
		fr[70] = fr[70] & 8'hdf;
		{fr[74], fr[75]} = fs;
		fr[77] = fr[77] | 8'h01;
		fr[81] = fr[81] | 8'h01;
		for (int i = 0; i < 8; i++) pn[63 - 8 * i -: 8] = fr[20 + i];
		if (ov[23:16] != 8'hff) {fr[ov[23:16]], fr[ov[23:16] + 1]} = ov[15:0];
		expect_reply(k, {2'b00, p}, fs);
		xfer(p, 1'b1, 1'b0);
	endtask
	task automatic prli(input logic [1:0] p, input int k);
		fr = {};
		for (int i = 0; i < 20; i++) fr.push_back(8'($urandom));
		{fr[0], fr[1], fr[2], fr[3], fr[4], fr[5], fr[6], fr[7]} = 64'h2010001408002000;
		{fr[16], fr[17], fr[18], fr[19]} = 32'h00000022;
		expect_reply(k, 4'h0, 16'h0);
		xfer(p, 1'b1, 1'b0);
	endtask

	// ----------------
	// result watchers
	// ----------------
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			nFail++;
			complete_run();
		end
		if (txValid === 1'b1 && txReady === 1'b1) begin
			chk("tx eof port", {30'h0, txq.size() == 1, ep}, {30'h0, txEof, txPort});
			chk("tx byte", {25'h0, txq.size() != 0 ? txq.pop_front() : 8'hxx}, {25'h0, txData});
		end
		if (tmfRespValid === 1'b1)
			chk("tmf code", {25'h0, tq.size() != 0 ? tq.pop_front() : 8'hxx}, {25'h0, tmfResp});
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
			chk("apb read", ae.pop_front(), {pslverr, prdata} & am.pop_front());
	end

	// ----------------
	// main sequence
	// ----------------
	initial begin
		void'($urandom(32'hd0ea));
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		uid = 24'($urandom);
		mk = 24'($urandom);
		apb(1'b0, REG_UID, '0, {9'h0, UID_RST}, 33'h1_00ff_ffff);
		apb(1'b0, REG_MAKER, '0, {9'h0, MAKER_RST}, 33'h1_00ff_ffff);
		apb(1'b1, REG_UID, {8'h0, uid}, '0, '0);
		apb(1'b1, REG_MAKER, {8'h0, mk}, '0, '0);
		apb(1'b0, REG_MAKER, '0, {9'h0, mk}, 33'h1_00ff_ffff);
		apb(1'b0, 8'h28, '0, 33'h1_0000_0000, 33'h1_ffff_ffff);
		apb(1'b0, REG_STATUS, '0, '0, 33'h1_0000_003f);
		$display("test registers finished");
		for (int i = 0; i < 24; i++) begin
			f = i < 9 ? tab[i] : 8'($urandom);
			tq.push_back(f inside {8'h02, 8'h04, 8'h20, 8'h40} ? 8'h00 : 8'(f == 8'h80 ? 4 : 5));
			tmfValid <= 1'b1;
			tmfFlags <= f;
			@(posedge mclk);
		end
		tmfValid <= 1'b0;
		repeat (3) @(posedge mclk);
		$display("test task management finished");
		foreach (bad[i]) plogi(2'd1, 16'h0200, bad[i], 2);
		prli(2'd1, 2);
		plogi(2'd0, 16'h0200, 24'hffffff, 0);
		plogi(2'd2, 16'h083c, 24'hffffff, 0);
		plogi(2'd1, 16'h0084, 24'h4610ff, 0);
		prli(2'd1, 1);
		prli(2'd2, 1);
		apb(1'b0, REG_RXSIZE, '0, {1'b0, 16'h083c, 16'h0084}, 33'h1_ffff_ffff);
		apb(1'b0, REG_STATUS, '0, 33'h0_0000_000f, 33'h1_0000_003f);
		$display("test logins finished");
		for (int n = 0; n < 3; n++) begin
			fr = {};
			repeat (n == 0 ? 132 : 100) fr.push_back(8'($urandom));
			xfer(2'd1, 1'b0, n == 2);
			apb(1'b0, REG_STATUS, '0, {28'h0, n != 0, 4'h0}, 33'h1_0000_0010);
		end
		apb(1'b1, REG_STATUS, 32'h10, '0, '0);
		apb(1'b0, REG_STATUS, '0, '0, 33'h1_0000_0010);
		$display("test frame size finished");
		for (int p = 1; p < 3; p++) begin
			ep = 2'(p);
			expect_reply(3, 4'(p), 16'h0840);
			apb(1'b1, REG_CTRL, 32'(p * 2 + 1), '0, '0);
			wait_reply();
		end
		$display("test fabric login finished");
		for (int k = 0; k < 2; k++) begin
			fr = {};
			for (int i = 0; i < 28; i++) fr.push_back(i == 0 ? 8'h50 : (i > 19 ? pn[223 - 8 * i -: 8] : 8'h00));
			if (k == 1) fr[27] = ~fr[27];
			expect_reply(k * 2, 4'h1, 16'h0084);
			xfer(2'd1, 1'b1, 1'b0);
		end
		apb(1'b0, REG_STATUS, '0, 33'h0_0000_0022, 33'h1_0000_0023);
		$display("test discovery finished");
		complete_run();
	end
endmodule
